// file: verilog/bmsl_loader.sv
// boot strap decode and serial loader link engine
// What this block does
// - sample four straps once, choose path
// - first strap high: jump to flash entry
// - first strap pulled up, others not
// - low,high: start SPI EEPROM loader
// - low,low,high,high: start serial loader
// - low,low,high,low: jump to on-chip RAM
// - low,low,low,high: jump to OTP entry
// - all low: start parallel port loader
// - jump paths load no external code
// - 8 data bits, no parity, one stop
// - autobaud on letter a sets bit rate
// - echo autobaud character after lock
// - echo every kernel byte received
// - relock bit rate after clock raise
// - send flash checksum low byte, zero means erased
// - expected checksum ends sequence early
// - erase uninterrupted, then report done
// - program, checksum, compare, report match or mismatch
// - report unlock failure, stop programming
// - only binary byte stream accepted
`timescale 1ns/100ps
module bmsl_loader
  import bmsl_pkg::*;
#(
  parameter logic [15:0] CSUM_EXPECTED = CSUM_EXPECTED_DEF
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire logic                clk_en_i,
  input  wire logic [3:0]          boot_strap_i,
  output logic [3:0]               strap_pullup_o,
  output bmsl_boot_sel_type        boot_sel_o,
  input  wire logic                serial_rx_i,
  output logic                     serial_tx_pin_o,
  output logic                     serial_tx_oe_o,
  output logic [7:0]               rx_data_o,
  output logic                     rx_valid_o,
  input  wire logic                kernel_done_i,
  input  wire logic                relock_i,
  input  wire bmsl_flash_stat_type flash_stat_i,
  input  wire logic                prog_done_i,
  output logic                     erase_req_o,
  output logic                     prog_start_o,
  output logic                     seq_end_o
);
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_BAUD     = 4'b0001,
    ST_KERNEL   = 4'b0010,
    ST_WAIT_CS  = 4'b0011,
    ST_PROMPT   = 4'b0100,
    ST_ERASE    = 4'b0101,
    ST_IMAGE    = 4'b0110,
    ST_VERIFY   = 4'b0111,
    ST_END      = 4'b1000,
    ST_RELOCK   = 4'b1001
  } bmsl_state_type;

  bmsl_state_type         state;
  logic                   sampled;
  logic                   serial_mode;
  bmsl_boot_sel_type      strap_dec;
  // receiver
  logic [1:0]             rx_sync;
  logic                   rx_prev;
  logic [BIT_CNT_W-1:0]   bit_cycles;
  logic [BIT_CNT_W-1:0]   meas_cnt;
  logic                   locked;
  logic                   measuring;
  logic                   rx_busy;
  logic [BIT_CNT_W-1:0]   rx_cnt;
  logic [3:0]             rx_bit;
  logic [7:0]             rx_shift;
  logic                   rx_done;
  // transmitter
  logic                   tx_busy;
  logic [BIT_CNT_W-1:0]   tx_cnt;
  logic [3:0]             tx_bit;
  logic [9:0]             tx_shift;
  logic                   tx_req;
  logic [7:0]             tx_byte;
  logic                   rx_line;

  function automatic bmsl_boot_sel_type decode_straps(input logic [3:0] s);
    bmsl_boot_sel_type r;
    r = '{valid: 1'b1, mode: BOOT_PARALLEL, jump: 1'b0, addr: 22'h000000};
    if (s[0]) begin
      r.mode = BOOT_FLASH; r.jump = 1'b1; r.addr = ADDR_FLASH_ENTRY;
    end else if (s[1]) begin
      r.mode = BOOT_SPI;
    end else if (s[2] && s[3]) begin
      r.mode = BOOT_SERIAL;
    end else if (s[2]) begin
      r.mode = BOOT_RAM; r.jump = 1'b1; r.addr = ADDR_RAM_ENTRY;
    end else if (s[3]) begin
      r.mode = BOOT_OTP; r.jump = 1'b1; r.addr = ADDR_OTP_ENTRY;
    end
    return r;
  endfunction : decode_straps

  function automatic logic is_autobaud(input logic [7:0] c);
    return (c == CHAR_LOWER_A) || (c == CHAR_UPPER_A);
  endfunction : is_autobaud

  assign strap_pullup_o = 4'h1;
  assign serial_tx_oe_o = serial_mode;
  assign rx_line        = rx_sync[1];
  assign strap_dec      = decode_straps(boot_strap_i);

  // the bit timer must span one and a half bit times of the slowest host
  if (BIT_CNT_W < 8) begin : g_bad_width
    $error("bit counter too narrow");
  end

  // straps sampled once after reset release; later toggles are ignored
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sampled     <= 1'b0;
      serial_mode <= 1'b0;
      boot_sel_o  <= '{valid: 1'b0, mode: BOOT_FLASH, jump: 1'b0, addr: 22'h000000};
    end else if (clk_en_i && !sampled) begin
      sampled     <= 1'b1;
      boot_sel_o  <= strap_dec;
      // only the serial path ever drives the transmit pin
      serial_mode <= (strap_dec.mode == BOOT_SERIAL);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_sync <= 2'b11;
      rx_prev <= 1'b1;
    end else if (clk_en_i) begin
      rx_sync <= {rx_sync[0], serial_rx_i};
      rx_prev <= rx_line;
    end
  end

  // autobaud: 'a'/'A' start bit plus data bit 0 (high) gives one low bit
  // then a high bit; measure the low run as one bit time
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      locked     <= 1'b0;
      measuring  <= 1'b0;
      meas_cnt   <= '0;
      bit_cycles <= '0;
    end else if (clk_en_i) begin
      if (!serial_mode || state == ST_IDLE) begin
        locked <= 1'b0;
      end else if (relock_i) begin
        locked <= 1'b0;
      end else if (!locked) begin
        // only a start bit opens a measurement; low runs inside a byte
        // (four bits long in 'a') would otherwise spoil the bit time
        if (!measuring && !rx_busy && rx_prev && !rx_line) begin
          measuring <= 1'b1;
          meas_cnt  <= BIT_CNT_W'(1);
        end else if (measuring && rx_line) begin
          measuring  <= 1'b0;
          bit_cycles <= meas_cnt;
        end else if (measuring) begin
          meas_cnt <= meas_cnt + BIT_CNT_W'(1);
        end
        if (rx_done && is_autobaud(rx_shift)) begin
          locked <= 1'b1;
        end
      end
    end
  end

  // receiver: 8N1 (the first char before lock runs on measured time)
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_busy  <= 1'b0;
      rx_cnt   <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_done  <= 1'b0;
    end else if (clk_en_i) begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (serial_mode && rx_prev && !rx_line) begin
          rx_busy <= 1'b1;
          rx_bit  <= 4'h0;
          rx_cnt  <= '0;
        end
      end else if (bit_cycles == '0) begin
        // first frame ever: count on until the measured bit time lands
        rx_cnt <= rx_cnt + BIT_CNT_W'(1);
      end else if (rx_cnt == ((rx_bit == 4'h0) ? (bit_cycles + (bit_cycles >> 1))
                                                : bit_cycles) - BIT_CNT_W'(1)) begin
        rx_cnt <= '0;
        if (rx_bit == DATA_BITS) begin
          rx_busy <= 1'b0;
          rx_done <= rx_line;                                           // framing error drops
        end else begin
          rx_shift <= {rx_line, rx_shift[7:1]};
          rx_bit   <= rx_bit + 4'h1;
        end
      end else begin
        rx_cnt <= rx_cnt + BIT_CNT_W'(1);
      end
    end
  end

  assign rx_data_o  = rx_shift;
  assign rx_valid_o = rx_done && locked && (state != ST_BAUD);

  // sequencer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state        <= ST_IDLE;
      tx_req       <= 1'b0;
      tx_byte      <= '0;
      erase_req_o  <= 1'b0;
      prog_start_o <= 1'b0;
      seq_end_o    <= 1'b0;
    end else if (clk_en_i) begin
      tx_req       <= 1'b0;
      prog_start_o <= 1'b0;
      unique case (state)
        ST_IDLE: if (sampled && serial_mode) state <= ST_BAUD;
        ST_BAUD: if (!locked && rx_done && is_autobaud(rx_shift)) begin
          tx_req  <= 1'b1;
          tx_byte <= rx_shift;
          state   <= ST_KERNEL;
        end
        ST_KERNEL: begin
          if (rx_done && locked) begin
            tx_req  <= 1'b1;
            tx_byte <= rx_shift;
          end
          if (kernel_done_i) state <= ST_RELOCK;
        end
        // a failed unlock is reported at once; otherwise the checksum is
        // held back until the host has relocked at the raised clock, as
        // the old bit time no longer matches once the clock has changed
        ST_RELOCK: begin
          if (flash_stat_i.unlock_fail) begin
            if (!tx_busy && !tx_req) begin
              tx_req  <= 1'b1;
              tx_byte <= {4'h0, RESP_UNLOCK_FAIL};
              state   <= ST_END;
            end
          end else if (!locked && rx_done && is_autobaud(rx_shift)) begin
            tx_req  <= 1'b1;
            tx_byte <= rx_shift;
            state   <= ST_WAIT_CS;
          end
        end
        ST_WAIT_CS: begin
          if (locked && flash_stat_i.done && !tx_busy && !tx_req) begin
            tx_req  <= 1'b1;
            tx_byte <= flash_stat_i.csum[7:0];
            if (flash_stat_i.csum == CSUM_EXPECTED) begin
              state <= ST_END;
            end else if (flash_stat_i.csum == CSUM_ERASED) begin
              state <= ST_IMAGE;
              prog_start_o <= 1'b1;
            end else begin
              state <= ST_PROMPT;
            end
          end
        end
        ST_PROMPT: if (rx_done && locked) begin
          if (rx_shift == CHAR_YES) begin
            erase_req_o <= 1'b1;
            state       <= ST_ERASE;
          end
        end
        ST_ERASE: if (flash_stat_i.erase_done) begin
          erase_req_o  <= 1'b0;
          tx_req       <= 1'b1;
          tx_byte      <= {4'h0, RESP_ERASE_DONE};
          prog_start_o <= 1'b1;
          state        <= ST_IMAGE;
        end
        ST_IMAGE: if (prog_done_i) state <= ST_VERIFY;
        ST_VERIFY: if (flash_stat_i.done && !tx_busy && !tx_req) begin
          tx_req  <= 1'b1;
          tx_byte <= (flash_stat_i.csum == CSUM_EXPECTED) ? {4'h0, RESP_MATCH}
                                                          : {4'h0, RESP_MISMATCH};
          state   <= ST_END;
        end
        ST_END: seq_end_o <= 1'b1;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // transmitter, 8N1 at the locked bit time
  // one byte in flight only: a request seen while busy is lost, so an
  // echo keeps pace only with a host that leaves at least one idle cycle after each stop bit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_busy         <= 1'b0;
      tx_cnt          <= '0;
      tx_bit          <= '0;
      tx_shift        <= 10'h3FF;
      serial_tx_pin_o <= 1'b1;
    end else if (clk_en_i) begin
      if (!tx_busy) begin
        serial_tx_pin_o <= 1'b1;
        if (tx_req) begin
          tx_busy  <= 1'b1;
          tx_shift <= {1'b1, tx_byte, 1'b0};
          tx_cnt   <= '0;
          tx_bit   <= '0;
        end
      end else begin
        serial_tx_pin_o <= tx_shift[0];
        if (tx_cnt == bit_cycles - BIT_CNT_W'(1)) begin
          tx_cnt   <= '0;
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_bit   <= tx_bit + 4'h1;
          if (tx_bit == 4'h9) tx_busy <= 1'b0;
        end else begin
          tx_cnt <= tx_cnt + BIT_CNT_W'(1);
        end
      end
    end
  end
endmodule : bmsl_loader

// file: verilog/bmsl_pkg.sv
// package: constants and types for the boot mode serial loader
package bmsl_pkg;
  localparam int          CLK_MHZ          = 250;
  localparam logic [21:0] ADDR_FLASH_ENTRY = 22'h3F7FF6;
  localparam logic [21:0] ADDR_RAM_ENTRY   = 22'h3F8000;
  localparam logic [21:0] ADDR_OTP_ENTRY   = 22'h3D7800;
  localparam logic [7:0]  CHAR_LOWER_A     = 8'h61;
  localparam logic [7:0]  CHAR_UPPER_A     = 8'h41;
  localparam logic [7:0]  CHAR_YES         = 8'h79;
  localparam logic [15:0] CSUM_ERASED      = 16'h0000;
  localparam logic [15:0] CSUM_EXPECTED_DEF = 16'h0000;
  localparam int          BIT_CNT_W        = 20;
  localparam logic [3:0]  DATA_BITS        = 4'h8;
  localparam int          RESP_W           = 4;
  localparam logic [3:0]  RESP_CSUM_LO     = 4'h1;
  localparam logic [3:0]  RESP_CSUM_HI     = 4'h2;
  localparam logic [3:0]  RESP_ERASE_DONE  = 4'h3;
  localparam logic [3:0]  RESP_MATCH       = 4'h4;
  localparam logic [3:0]  RESP_MISMATCH    = 4'h5;
  localparam logic [3:0]  RESP_UNLOCK_FAIL = 4'h6;
  localparam logic [3:0]  RESP_ALREADY_OK  = 4'h7;

  typedef enum logic [2:0] {
    BOOT_FLASH    = 3'b000,
    BOOT_SPI      = 3'b001,
    BOOT_SERIAL   = 3'b010,
    BOOT_RAM      = 3'b011,
    BOOT_OTP      = 3'b100,
    BOOT_PARALLEL = 3'b101
  } bmsl_boot_type;

  typedef struct packed {
    logic        valid;
    bmsl_boot_type mode;
    logic        jump;
    logic [21:0] addr;
  } bmsl_boot_sel_type;

  typedef struct packed {
    logic        done;
    logic        unlock_fail;
    logic        erase_done;
    logic [15:0] csum;
  } bmsl_flash_stat_type;
endpackage : bmsl_pkg

// file: testbench/bmsl_chk_assertions.sv
// checker: strap decode and serial pin assertions
`timescale 1ns/100ps
module bmsl_chk
  import bmsl_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rst_n_i,
  input wire logic [3:0]        boot_strap_i,
  input wire logic [3:0]        strap_pullup_o,
  input wire bmsl_boot_sel_type boot_sel_o,
  input wire logic              serial_tx_pin_o,
  input wire logic              serial_tx_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_flash; $rose(boot_sel_o.valid) && $past(boot_strap_i[0]) |->
    boot_sel_o.mode == BOOT_FLASH && boot_sel_o.addr == ADDR_FLASH_ENTRY; endproperty
  a_flash: assert property (p_flash) else $error("flash path wrong");
  property p_spi; $rose(boot_sel_o.valid) && $past(boot_strap_i[1:0]) == 2'h2 |->
    boot_sel_o.mode == BOOT_SPI && !boot_sel_o.jump; endproperty
  a_spi: assert property (p_spi) else $error("spi path wrong");
  property p_serial; $rose(boot_sel_o.valid) && $past(boot_strap_i) == 4'hC |->
    boot_sel_o.mode == BOOT_SERIAL; endproperty
  a_serial: assert property (p_serial) else $error("serial path wrong");
  property p_ram; $rose(boot_sel_o.valid) && $past(boot_strap_i) == 4'h4 |->
    boot_sel_o.mode == BOOT_RAM && boot_sel_o.addr == ADDR_RAM_ENTRY; endproperty
  a_ram: assert property (p_ram) else $error("ram path wrong");
  property p_otp; $rose(boot_sel_o.valid) && $past(boot_strap_i) == 4'h8 |->
    boot_sel_o.mode == BOOT_OTP && boot_sel_o.addr == ADDR_OTP_ENTRY; endproperty
  a_otp: assert property (p_otp) else $error("otp path wrong");
  property p_par; $rose(boot_sel_o.valid) && $past(boot_strap_i) == 4'h0 |->
    boot_sel_o.mode == BOOT_PARALLEL; endproperty
  a_par: assert property (p_par) else $error("parallel path wrong");
  property p_hold; boot_sel_o.valid && $past(boot_sel_o.valid) |-> $stable(boot_sel_o); endproperty
  a_hold: assert property (p_hold) else $error("boot selection changed");
  property p_pull; strap_pullup_o == 4'h1; endproperty
  a_pull: assert property (p_pull) else $error("pull-up pattern wrong");
  property p_jump; boot_sel_o.valid |->
    boot_sel_o.jump == (boot_sel_o.mode inside {BOOT_FLASH, BOOT_RAM, BOOT_OTP}); endproperty
  a_jump: assert property (p_jump) else $error("jump flag wrong");
  property p_quiet; boot_sel_o.valid && boot_sel_o.mode != BOOT_SERIAL |->
    !serial_tx_oe_o && serial_tx_pin_o; endproperty
  a_quiet: assert property (p_quiet) else $error("serial pin active off path");
endmodule : bmsl_chk
bind bmsl_loader bmsl_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .boot_strap_i(boot_strap_i), .strap_pullup_o(strap_pullup_o), .boot_sel_o(boot_sel_o),
  .serial_tx_pin_o(serial_tx_pin_o), .serial_tx_oe_o(serial_tx_oe_o));

// file: testbench/bmsl_host.sv
// partner model: host side of the serial loader link
`timescale 1ns/100ps
module bmsl_host #(
  parameter int BIT = 16
) (
  input  wire logic clk_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  logic [7:0] got [$];
  int         bit_t = BIT;
  initial rx_o = 1'b1; // idle high between frames
  // lsb first, no parity, one stop; gap lets the host be slow
  task automatic send(input logic [7:0] b, input int gap);
    repeat (gap + 1) @(negedge clk_i);
    rx_o = 1'b0;
    repeat (bit_t) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rx_o = b[i];
      repeat (bit_t) @(negedge clk_i);
    end
    rx_o = 1'b1;
    repeat (bit_t) @(negedge clk_i);
  endtask : send
  // mid-bit sampling; frames with a bad start or stop are dropped
  always begin : rx_mon
    logic [7:0] v;
    @(negedge tx_i);
    repeat (bit_t / 2) @(posedge clk_i);
    if (tx_i === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_t) @(posedge clk_i);
        v[i] = tx_i;
      end
      repeat (bit_t) @(posedge clk_i);
      if (tx_i === 1'b1) got.push_back(v);
    end
  end
endmodule : bmsl_host

// file: testbench/bmsl_loader_tb.sv
// testbench: strap decode and serial loader link flow
`timescale 1ns/100ps
module bmsl_loader_tb
  import bmsl_pkg::*;
;
  localparam logic [15:0] CSUMX = 16'h5A5A;
  logic                mclk, rst_n, kdone, relock, pdone, rx, tx, oe, rxv, ereq, pst, send;
  logic [3:0]          straps, pull;
  logic [7:0]          rxd, last;
  bmsl_boot_sel_type   bsel;
  bmsl_flash_stat_type fstat;
  int                  n_mismatch = 0;
  int                  check_count = 0;
  int                  n_pst = 0;
  bmsl_loader #(.CSUM_EXPECTED(CSUMX)) dut (.mclk_i(mclk), .rst_n_i(rst_n), .clk_en_i(1'b1),
    .boot_strap_i(straps), .strap_pullup_o(pull), .boot_sel_o(bsel), .serial_rx_i(rx),
    .serial_tx_pin_o(tx), .serial_tx_oe_o(oe), .rx_data_o(rxd), .rx_valid_o(rxv),
    .kernel_done_i(kdone), .relock_i(relock), .flash_stat_i(fstat), .prog_done_i(pdone),
    .erase_req_o(ereq), .prog_start_o(pst), .seq_end_o(send));
  bmsl_host #(.BIT(16)) host (.clk_i(mclk), .tx_i(tx), .rx_o(rx));
  // sampled mid-cycle, away from the edge that launches the pulses
  always @(negedge mclk) if (rxv === 1'b1) last <= rxd;
  always @(negedge mclk) if (pst === 1'b1) n_pst <= n_pst + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // pops up to n bytes looking for e; a missing byte reads as unknown
  task automatic get(input logic [7:0] e, input string nm, input int n = 1);
    logic [7:0] g;
    g = 8'hXX;
    for (int k = 0; k < n && g !== e; k++) begin
      g = 8'hXX;
      for (int i = 0; i < 3000 && host.got.size() == 0; i++) @(negedge mclk);
      if (host.got.size() != 0) g = host.got.pop_front();
    end
    chk(nm, e, g);
  endtask : get
  task automatic do_reset(input logic [3:0] s);
    @(negedge mclk);
    rst_n = 1'b0;
    straps = s;
    fstat = '0;
    pdone = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    host.got.delete();
    host.bit_t = 16;
  endtask : do_reset
  task automatic t_straps;
    logic [3:0] s [8] = '{4'h1, 4'hF, 4'h2, 4'hE, 4'hC, 4'h4, 4'h8, 4'h0};
    bmsl_boot_type m [8] = '{BOOT_FLASH, BOOT_FLASH, BOOT_SPI, BOOT_SPI, BOOT_SERIAL,
      BOOT_RAM, BOOT_OTP, BOOT_PARALLEL};
    logic [21:0] a [8] = '{ADDR_FLASH_ENTRY, ADDR_FLASH_ENTRY, 22'h0, 22'h0, 22'h0,
      ADDR_RAM_ENTRY, ADDR_OTP_ENTRY, 22'h0};
    for (int i = 0; i < 8; i++) begin
      do_reset(s[i]);
      straps = ~s[i];
      repeat (3) @(negedge mclk);
      chk("mode", m[i], bsel.mode);
      chk("jump", a[i] != 22'h0, bsel.jump);
      if (a[i] != 22'h0) chk("addr", a[i], bsel.addr);
      chk("tx enable", m[i] == BOOT_SERIAL, oe);
      chk("pull-up", 4'h1, pull);
    end
  endtask : t_straps
  task automatic lock;
    do_reset(4'hC);
    host.send(8'h55, 0);
    repeat (300) @(negedge mclk);
    chk("early echo", 0, host.got.size());
    host.send(CHAR_LOWER_A, 40);
    get(CHAR_LOWER_A, "baud echo");
  endtask : lock
  task automatic kernel_up;
    @(negedge mclk);
    kdone = 1'b1;
    @(negedge mclk);
    kdone = 1'b0;
    relock = 1'b1;
    @(negedge mclk);
    relock = 1'b0;
  endtask : kernel_up
  task automatic t_full;
    lock();
    host.send(8'h3C, 0);
    host.send(8'hA5, 0);
    get(8'h3C, "kernel echo");
    get(8'hA5, "kernel echo");
    chk("rx data", 8'hA5, last);
    fstat = {1'b1, 1'b0, 1'b0, 16'h1234};
    kernel_up();
    host.bit_t = 12;
    host.send(CHAR_UPPER_A, 0);
    get(CHAR_UPPER_A, "relock echo");
    get(8'h34, "checksum");
    host.send(8'h6E, 0);
    repeat (100) @(negedge mclk);
    chk("erase on no", 1'b0, ereq);
    host.send(CHAR_YES, 0);
    for (int i = 0; i < 500 && ereq !== 1'b1; i++) @(negedge mclk);
    chk("erase", 1'b1, ereq);
    fstat.erase_done = 1'b1;
    get({4'h0, RESP_ERASE_DONE}, "erase done");
    chk("prog start", 1, n_pst);
    fstat.csum = CSUMX;
    pdone = 1'b1;
    get({4'h0, RESP_MATCH}, "verify", 3);
    repeat (20) @(negedge mclk);
    chk("end", 1'b1, send);
  endtask : t_full
  task automatic t_early;
    lock();
    fstat = {1'b1, 1'b0, 1'b0, CSUMX};
    kernel_up();
    host.send(CHAR_LOWER_A, 0);
    get(CHAR_LOWER_A, "relock echo");
    get(CSUMX[7:0], "checksum");
    repeat (200) @(negedge mclk);
    chk("end", 1'b1, send);
    chk("prog start", 1, n_pst);
    chk("erase", 1'b0, ereq);
  endtask : t_early
  task automatic t_unlock;
    lock();
    fstat = {1'b1, 1'b1, 1'b0, 16'h1234};
    kernel_up();
    host.send(CHAR_LOWER_A, 0);
    get({4'h0, RESP_UNLOCK_FAIL}, "unlock", 3);
    chk("erase", 1'b0, ereq);
  endtask : t_unlock
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    straps = 4'hC;
    kdone = 1'b0;
    relock = 1'b0;
    pdone = 1'b0;
    fstat = '0;
    t_straps();
    t_full();
    t_early();
    t_unlock();
    end_sim();
  end
endmodule : bmsl_loader_tb
